// *** hdl/link_port_pkg.sv ***
// Constants shared by the serial link port: register map, fields, codes.
package link_port_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_TXDATA = 8'h0c;
  localparam logic [7:0] ADDR_RXLAST = 8'h10;
  localparam logic [7:0] ADDR_FIFOSTAT = 8'h14;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_MSB = 7;

  // ----------------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------------
  localparam int CTRL_FIFO_BYP_N = 0;
  localparam int CTRL_CODEC_BYP_N = 1;
  localparam int CTRL_WIDTH_SEL = 2;
  localparam int CTRL_POLICY_LSB = 4;
  localparam int POLICY_W = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0003;
  localparam logic [POLICY_W-1:0] POLICY_KEEP = 2'h0;

  // ----------------------------------------------------------------------
  // Status and mask fields
  // ----------------------------------------------------------------------
  localparam int IRQ_W = 5;
  localparam int ST_REMOTE_RISE = 0;
  localparam int ST_REMOTE_FALL = 1;
  localparam int ST_PASS_DONE = 2;
  localparam int ST_CLEAR_DONE = 3;
  localparam int ST_TX_OVERFLOW = 4;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 5'h00;

  // ----------------------------------------------------------------------
  // Character layout and special codes
  // ----------------------------------------------------------------------
  localparam int RAW_W = 12;
  localparam int TXCHAR_W = 10;
  localparam int RAW_BIT8 = 8;
  localparam logic [7:0] CODE_K28_0 = 8'h1c;
  localparam logic [7:0] CODE_K28_3 = 8'h7c;

  // ----------------------------------------------------------------------
  // Timing and self-test constants
  // ----------------------------------------------------------------------
  localparam int CLEAR_LOW_EDGES = 8;
  localparam int CLEAR_CNT_W = 4;
  localparam int SEQ_W = 9;
  localparam int SEQ_TAP = 4;
  localparam logic [8:0] SEQ_SEED = 9'h1ff;
  localparam int SYNC_STAGES = 3;

endpackage

// *** hdl/selftest_seq.sv ***
// Repeating 511-character test sequence generator.
`timescale 1ns/1ns

module selftest_seq
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic restart,
  input wire logic step,
  output logic [link_port_pkg::SEQ_W-1:0] value,
  output logic passDone
);

  logic [link_port_pkg::SEQ_W-1:0] stateQ;
  logic [link_port_pkg::SEQ_W-1:0] stateD;
  logic feedback;

  // A maximal 9-bit shift register visits 511 states, one per character.
  assign feedback = stateQ[link_port_pkg::SEQ_W-1] ^
    stateQ[link_port_pkg::SEQ_TAP];
  assign stateD = {stateQ[link_port_pkg::SEQ_W-2:0], feedback};

  // Advance once per character; restart goes back to the seed.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b || restart)
      stateQ <= link_port_pkg::SEQ_SEED;
    else if (step)
      stateQ <= stateD;
  end

  assign value = stateQ;
  // The pass ends when the next character would be the seed again.
  assign passDone = step && (stateD == link_port_pkg::SEQ_SEED);

endmodule // selftest_seq

// *** hdl/serial_link_port.sv ***
// Transmit FIFO, self-test and receive parallel port of the serial link.
// What this block does
// - Clear transmit FIFO after eight low samples
// - Ignore clear input while FIFO bypassed
// - Self-test low sends 511-character repeating sequence
// - Self-test high resumes normal host data
// - No FIFO reads during self-test
// - Receive bus updates only when addressed, selected
// - Decoder bypassed: raw low eight bits out
// - K28.0 drives remote interrupt high
// - K28.3 drives remote interrupt low
// - Interrupt codes discarded unless policy zero
// - FIFO bypassed, decoder active: pin shows odd parity
// - Decoder bypassed: pin shows raw ninth bit
// - Empty flag pulses once per test pass
//
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ns

module serial_link_port
#(
  parameter int FIFO_DEPTH = 256,
  parameter int PTR_W = 8
)
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  input wire logic tx_par_clk,
  input wire logic rx_par_clk,
  input wire logic tx_fifo_clear_n,
  input wire logic tx_selftest_en_n,
  input wire logic addr_match_n,
  input wire logic rx_select_n,
  output logic tx_fifo_empty_flag,
  output logic [link_port_pkg::TXCHAR_W-1:0] txChar,
  output logic txCharValid,
  input wire logic [link_port_pkg::RAW_W-1:0] rxLinkChar,
  input wire logic rxLinkSpecial,
  input wire logic rxLinkValid,
  output logic [7:0] rx_par_bus,
  output logic rxParBusOeN,
  output logic rx_special_flag,
  output logic remote_irq_out,
  output logic remoteIrqOeN
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  localparam int NPIN = 6;
  logic [NPIN-1:0] pinRaw;
  logic [NPIN-1:0] pinQ;
  logic [NPIN-1:0] pinPrevQ;
  logic [NPIN-1:0] pinRise;

  assign pinRaw = {rx_select_n, addr_match_n, tx_selftest_en_n,
                   tx_fifo_clear_n, rx_par_clk, tx_par_clk};

  // Three stages per pin; a level only counts once stages two and three
  // agree, so a late-settling first stage cannot produce a glitch.
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_sync
      logic [link_port_pkg::SYNC_STAGES-1:0] stageQ;
      always_ff @(posedge clk_sys)
      begin
        if (!rst_b)
          stageQ <= '1;
        else
          stageQ <= {stageQ[link_port_pkg::SYNC_STAGES-2:0], pinRaw[gi]};
      end
      always_ff @(posedge clk_sys)
      begin
        if (!rst_b)
          pinQ[gi] <= 1'b1;
        else if (stageQ[1] == stageQ[2])
          pinQ[gi] <= stageQ[2];
      end
    end
  endgenerate

  // Edge history of the filtered levels.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      pinPrevQ <= '1;
    else
      pinPrevQ <= pinQ;
  end

  assign pinRise = pinQ & ~pinPrevQ;

  logic txEdge;
  logic rxEdge;
  logic clearLowN;
  logic selftestOn;
  logic rxEnabled;
  assign txEdge = pinRise[0];
  assign rxEdge = pinRise[1];
  assign clearLowN = pinQ[2];
  assign selftestOn = !pinQ[3];
  assign rxEnabled = !pinQ[4] && !pinQ[5];

  // ----------------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------------------------------------
  logic [31:0] ctrlQ;
  logic [link_port_pkg::IRQ_W-1:0] statusQ;
  logic [link_port_pkg::IRQ_W-1:0] maskQ;
  logic [link_port_pkg::IRQ_W-1:0] eventSet;
  logic [31:0] rdataD;
  logic [31:0] rdataQ;
  logic wrPendQ;
  logic [7:0] wrAddrQ;
  logic addrPhase;
  logic wrStatus;
  logic wrMask;
  logic wrCtrl;
  logic wrTxData;

  assign addrPhase = hsel && hready && htrans[1];
  assign wrCtrl = wrPendQ && (wrAddrQ == link_port_pkg::ADDR_CTRL);
  assign wrStatus = wrPendQ && (wrAddrQ == link_port_pkg::ADDR_STATUS);
  assign wrMask = wrPendQ && (wrAddrQ == link_port_pkg::ADDR_MASK);
  assign wrTxData = wrPendQ && (wrAddrQ == link_port_pkg::ADDR_TXDATA);

  logic fifoBypassN;
  logic codecBypassN;
  logic [link_port_pkg::POLICY_W-1:0] policy;
  assign fifoBypassN = ctrlQ[link_port_pkg::CTRL_FIFO_BYP_N];
  assign codecBypassN = ctrlQ[link_port_pkg::CTRL_CODEC_BYP_N];
  assign policy =
    ctrlQ[link_port_pkg::CTRL_POLICY_LSB +: link_port_pkg::POLICY_W];

  // Writes land in the data phase, using the address latched before it.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      wrPendQ <= 1'b0;
      wrAddrQ <= 8'h00;
    end
    else
    begin
      wrPendQ <= addrPhase && hwrite;
      wrAddrQ <= {haddr[link_port_pkg::ADDR_MSB:link_port_pkg::ADDR_LSB],
        2'b00};
    end
  end

  // Control and mask registers.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      ctrlQ <= link_port_pkg::CTRL_RESET;
      maskQ <= link_port_pkg::IRQ_RESET;
    end
    else
    begin
      if (wrCtrl)
        ctrlQ <= hwdata;
      if (wrMask)
        maskQ <= hwdata[link_port_pkg::IRQ_W-1:0];
    end
  end

  // Sticky status: a new event in the clearing cycle survives the clear.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      statusQ <= link_port_pkg::IRQ_RESET;
    else if (wrStatus)
      statusQ <= (statusQ & ~hwdata[link_port_pkg::IRQ_W-1:0]) | eventSet;
    else
      statusQ <= statusQ | eventSet;
  end

  // Interrupt output is registered, so it trails the status by one cycle.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      irq <= 1'b0;
    else
      irq <= |(statusQ & maskQ);
  end

  // ----------------------------------------------------------------------
  // Transmit FIFO
  // ----------------------------------------------------------------------
  logic [link_port_pkg::TXCHAR_W-1:0] fifoMem [FIFO_DEPTH];
  logic [PTR_W:0] wrPtrQ;
  logic [PTR_W:0] rdPtrQ;
  logic [PTR_W:0] fillLevel;
  logic fifoEmpty;
  logic fifoFull;
  logic [link_port_pkg::CLEAR_CNT_W-1:0] clearCntQ;
  logic clearFire;
  logic pushOk;
  logic popOk;

  assign fillLevel = wrPtrQ - rdPtrQ;
  assign fifoEmpty = (fillLevel == '0);
  assign fifoFull = (fillLevel == (PTR_W+1)'(FIFO_DEPTH));
  assign pushOk = wrTxData && !fifoFull;
  // Reads are held off entirely while the test sequence runs.
  assign popOk = txEdge && !selftestOn && !fifoEmpty;

  // Count consecutive low samples on transmit clock edges; fire once at
  // the eighth. Counting stops in bypass so the pin has no effect there.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b || !fifoBypassN)
      clearCntQ <= '0;
    else if (txEdge)
    begin
      if (clearLowN)
        clearCntQ <= '0;
      else if (clearCntQ <
        link_port_pkg::CLEAR_CNT_W'(link_port_pkg::CLEAR_LOW_EDGES))
        clearCntQ <= clearCntQ + 1'b1;
    end
  end

  assign clearFire = txEdge && !clearLowN && fifoBypassN &&
    (clearCntQ ==
     link_port_pkg::CLEAR_CNT_W'(link_port_pkg::CLEAR_LOW_EDGES - 1));

  // Write side; a clear drops a push arriving in the same cycle.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b || clearFire)
      wrPtrQ <= '0;
    else if (pushOk)
      wrPtrQ <= wrPtrQ + 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (pushOk)
      fifoMem[wrPtrQ[PTR_W-1:0]] <= hwdata[link_port_pkg::TXCHAR_W-1:0];
  end

  // Read side.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b || clearFire)
      rdPtrQ <= '0;
    else if (popOk)
      rdPtrQ <= rdPtrQ + 1'b1;
  end

  // ----------------------------------------------------------------------
  // Self-test sequence and transmit output
  // ----------------------------------------------------------------------
  logic [link_port_pkg::SEQ_W-1:0] seqValue;
  logic seqPassDone;

  selftest_seq u_seq
  (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .restart(!selftestOn),
    .step(txEdge && selftestOn),
    .value(seqValue),
    .passDone(seqPassDone)
  );

  // One character per transmit clock edge: test pattern or FIFO head.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      txChar <= '0;
      txCharValid <= 1'b0;
    end
    else if (txEdge && selftestOn)
    begin
      txChar <= link_port_pkg::TXCHAR_W'(seqValue[7:0]);
      txCharValid <= 1'b1;
    end
    else if (popOk)
    begin
      txChar <= fifoMem[rdPtrQ[PTR_W-1:0]];
      txCharValid <= 1'b1;
    end
    else
      txCharValid <= 1'b0;
  end

  // Empty flag: FIFO level normally, a pass marker during self-test that
  // stays up from one transmit edge to the next.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      tx_fifo_empty_flag <= 1'b1;
    else if (selftestOn)
    begin
      if (txEdge)
        tx_fifo_empty_flag <= seqPassDone;
    end
    else
      tx_fifo_empty_flag <= fifoEmpty || clearFire;
  end

  // ----------------------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------------------
  logic [link_port_pkg::RAW_W-1:0] rxHoldQ;
  logic rxHoldSpecialQ;
  logic remoteLevelQ;
  logic isIrqCode;
  logic codesActive;
  logic hitRise;
  logic hitFall;

  assign codesActive = fifoBypassN && codecBypassN;
  assign isIrqCode = rxLinkValid && rxLinkSpecial && codecBypassN &&
    ((rxLinkChar[7:0] == link_port_pkg::CODE_K28_0) ||
     (rxLinkChar[7:0] == link_port_pkg::CODE_K28_3));
  assign hitRise = rxLinkValid && rxLinkSpecial && codesActive &&
    (rxLinkChar[7:0] == link_port_pkg::CODE_K28_0);
  assign hitFall = rxLinkValid && rxLinkSpecial && codesActive &&
    (rxLinkChar[7:0] == link_port_pkg::CODE_K28_3);

  // Remote interrupt level mirrored from the in-band codes.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      remoteLevelQ <= 1'b0;
    else if (hitRise)
      remoteLevelQ <= 1'b1;
    else if (hitFall)
      remoteLevelQ <= 1'b0;
  end

  // Interrupt codes are taken out before storage unless policy keeps them.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      rxHoldQ <= '0;
      rxHoldSpecialQ <= 1'b0;
    end
    else if (rxLinkValid &&
      (!isIrqCode || policy == link_port_pkg::POLICY_KEEP))
    begin
      rxHoldQ <= rxLinkChar;
      rxHoldSpecialQ <= rxLinkSpecial;
    end
  end

  // Shared pin: raw ninth bit, parity or remote level, by mode.
  logic sharedPinD;
  always_comb
  begin
    sharedPinD = remoteLevelQ;
    if (!codecBypassN)
      sharedPinD = rxHoldQ[link_port_pkg::RAW_BIT8];
    else if (!fifoBypassN)
      sharedPinD = ~^{rxHoldQ[7:0], rxHoldSpecialQ};
  end

  // Outputs move only on a receive clock edge while addressed and
  // selected; an edge without both holds them and releases the bus.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      rx_par_bus <= 8'h00;
      rx_special_flag <= 1'b0;
      remote_irq_out <= 1'b0;
      rxParBusOeN <= 1'b1;
      remoteIrqOeN <= 1'b1;
    end
    else if (rxEdge)
    begin
      rxParBusOeN <= !rxEnabled;
      remoteIrqOeN <= !rxEnabled;
      if (rxEnabled)
      begin
        rx_par_bus <= rxHoldQ[7:0];
        rx_special_flag <= rxHoldSpecialQ && codecBypassN;
        remote_irq_out <= sharedPinD;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Event sources and read data
  // ----------------------------------------------------------------------
  always_comb
  begin
    eventSet = '0;
    eventSet[link_port_pkg::ST_REMOTE_RISE] = hitRise && !remoteLevelQ;
    eventSet[link_port_pkg::ST_REMOTE_FALL] = hitFall && remoteLevelQ;
    eventSet[link_port_pkg::ST_PASS_DONE] = seqPassDone;
    eventSet[link_port_pkg::ST_CLEAR_DONE] = clearFire;
    eventSet[link_port_pkg::ST_TX_OVERFLOW] = wrTxData && fifoFull;
  end

  always_comb
  begin
    rdataD = 32'h0000_0000;
    case ({haddr[link_port_pkg::ADDR_MSB:link_port_pkg::ADDR_LSB], 2'b00})
      link_port_pkg::ADDR_CTRL: rdataD = ctrlQ;
      link_port_pkg::ADDR_STATUS: rdataD = 32'(statusQ);
      link_port_pkg::ADDR_MASK: rdataD = 32'(maskQ);
      link_port_pkg::ADDR_RXLAST: rdataD = 32'({rxHoldSpecialQ, rxHoldQ});
      link_port_pkg::ADDR_FIFOSTAT: rdataD = 32'({remoteLevelQ, fifoFull,
                                                  fifoEmpty, fillLevel});
      default: rdataD = 32'h0000_0000;
    endcase
  end

  // Read data is captured at the address phase so it stands in the data
  // phase with no wait state.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      rdataQ <= 32'h0000_0000;
    else if (addrPhase && !hwrite)
      rdataQ <= rdataD;
  end

  // Always ready, always OKAY.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign hrdata = rdataQ;

endmodule // serial_link_port

// *** hdl/END_PLACEHOLDER_NONE.sv ***
// Empty file holding no logic.

// *** verification/serial_link_port_sva.sv ***
// Assertion checker for the serial link port, bound to its top module.
`timescale 1ns/1ns

module serial_link_port_sva
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic txCharValid,
  input wire logic [link_port_pkg::RAW_W-1:0] rxLinkChar,
  input wire logic rxLinkSpecial,
  input wire logic rxLinkValid,
  input wire logic [7:0] rx_par_bus,
  input wire logic rxParBusOeN,
  input wire logic rx_special_flag,
  input wire logic remote_irq_out
);
  // --------
  // Mode shadow
  // --------
  logic wrPend_q;
  logic [7:0] wrAddr_q;
  logic [31:0] ctrl_q;
  logic [link_port_pkg::RAW_W-1:0] raw_q;

  // Mirror control writes, since the port's meaning depends on the mode.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
      ctrl_q <= link_port_pkg::CTRL_RESET;
    end
    else
    begin
      wrPend_q <= hsel && hready && htrans[1] && hwrite;
      wrAddr_q <= haddr[7:0];
      if (wrPend_q && wrAddr_q == link_port_pkg::ADDR_CTRL)
        ctrl_q <= hwdata;
    end
  end

  // Last received character, the one the port presents next.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      raw_q <= 12'h000;
    else if (rxLinkValid)
      raw_q <= rxLinkChar;
  end

  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // --------
  // Properties
  // --------
  sequence s_code(logic [7:0] code);
    rxLinkValid && rxLinkSpecial && rxLinkChar[7:0] == code
      && ctrl_q[1:0] == 2'b11;
  endsequence
  sequence s_busMove;
    $changed(rx_par_bus);
  endsequence

  property p_oneChar;
    txCharValid |=> !txCharValid;
  endproperty
  property p_driveOnly;
    s_busMove |-> !rxParBusOeN;
  endproperty
  property p_rawLow;
    s_busMove ##0 !ctrl_q[1] |->
      rx_par_bus == raw_q[7:0] && !rx_special_flag;
  endproperty
  property p_rawNinth;
    s_busMove ##0 !ctrl_q[1] |->
      remote_irq_out == raw_q[link_port_pkg::RAW_BIT8];
  endproperty
  property p_parity;
    s_busMove ##0 ctrl_q[1:0] == 2'b10 |->
      remote_irq_out == ~^{rx_par_bus, rx_special_flag};
  endproperty
  property p_rise;
    s_code(link_port_pkg::CODE_K28_0) |-> ##[1:40] remote_irq_out;
  endproperty
  property p_fall;
    s_code(link_port_pkg::CODE_K28_3) |-> ##[1:40] !remote_irq_out;
  endproperty
  property p_drop;
    (ctrl_q[5:4] != 2'h0) ##0 s_code(link_port_pkg::CODE_K28_0) |=>
      $stable(rx_par_bus)[*8] ##1 $stable(rx_par_bus)[*8];
  endproperty

  a_oneChar: assert property (p_oneChar)
    else $error("character valid held two cycles");
  a_driveOnly: assert property (p_driveOnly)
    else $error("receive bus moved while not driving");
  a_rawLow: assert property (p_rawLow)
    else $error("raw low byte wrong on receive bus");
  a_rawNinth: assert property (p_rawNinth)
    else $error("shared pin is not raw bit eight");
  a_parity: assert property (p_parity)
    else $error("shared pin is not odd parity");
  a_rise: assert property (p_rise)
    else $error("remote interrupt did not rise");
  a_fall: assert property (p_fall)
    else $error("remote interrupt did not fall");
  a_drop: assert property (p_drop)
    else $error("interrupt code reached receive bus");
endmodule // serial_link_port_sva

bind serial_link_port serial_link_port_sva i_sva
(
  .clk_sys(clk_sys),
  .rst_b(rst_b),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hwdata(hwdata),
  .hready(hready),
  .txCharValid(txCharValid),
  .rxLinkChar(rxLinkChar),
  .rxLinkSpecial(rxLinkSpecial),
  .rxLinkValid(rxLinkValid),
  .rx_par_bus(rx_par_bus),
  .rxParBusOeN(rxParBusOeN),
  .rx_special_flag(rx_special_flag),
  .remote_irq_out(remote_irq_out)
);

// *** verification/link_partner.sv ***
// Far-side model: character clocks and characters from the deserialiser.
`timescale 1ns/1ns

module link_partner
(
  input wire logic clk_sys,
  output logic tx_par_clk,
  output logic rx_par_clk,
  output logic [link_port_pkg::RAW_W-1:0] rxLinkChar,
  output logic rxLinkSpecial,
  output logic rxLinkValid
);
  // Clocks rest low between slots; character lines idle at junk.
  initial
  begin
    tx_par_clk = 1'b0;
    rx_par_clk = 1'b0;
    rxLinkChar = 12'hfff;
    rxLinkSpecial = 1'b1;
    rxLinkValid = 1'b0;
  end

  // One transmit slot, slow enough for the three-stage pin filter.
  task automatic tx_slot();
    @(posedge clk_sys);
    tx_par_clk <= 1'b1;
    repeat (6) @(posedge clk_sys);
    tx_par_clk <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask

  // One received character, then the receive clock edge that shows it.
  task automatic rx_char(input logic [11:0] c, input logic s);
    @(posedge clk_sys);
    rxLinkChar <= c;
    rxLinkSpecial <= s;
    rxLinkValid <= 1'b1;
    @(posedge clk_sys);
    rxLinkValid <= 1'b0;
    rxLinkChar <= ~c;
    rxLinkSpecial <= ~s;
    rx_par_clk <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rx_par_clk <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask
endmodule // link_partner

// *** verification/serial_link_port_test.sv ***
// Self-checking testbench for the serial link port.
`timescale 1ns/1ns

module serial_link_port_test;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, irq, tx_par_clk, rx_par_clk;
  logic tx_fifo_clear_n = 1'b1;
  logic tx_selftest_en_n = 1'b1;
  logic addr_match_n = 1'b1;
  logic rx_select_n = 1'b1;
  logic tx_fifo_empty_flag, txCharValid, rxLinkSpecial, rxLinkValid;
  logic [link_port_pkg::TXCHAR_W-1:0] txChar, lastTx;
  logic [link_port_pkg::RAW_W-1:0] rxLinkChar;
  logic [7:0] rx_par_bus;
  logic rxParBusOeN, rx_special_flag, remote_irq_out, remoteIrqOeN;
  int txCount = 0;
  int base, i;
  int numErrors = 0;
  int totalChecks = 0;

  always #10 clk_sys = ~clk_sys;

  // Small FIFO so that overflow and clear are reached quickly.
  serial_link_port #(.FIFO_DEPTH(4), .PTR_W(2)) i_dut (.clk_sys(clk_sys),
    .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .tx_par_clk(tx_par_clk), .rx_par_clk(rx_par_clk),
    .tx_fifo_clear_n(tx_fifo_clear_n), .tx_selftest_en_n(tx_selftest_en_n),
    .addr_match_n(addr_match_n), .rx_select_n(rx_select_n),
    .tx_fifo_empty_flag(tx_fifo_empty_flag), .txChar(txChar),
    .txCharValid(txCharValid), .rxLinkChar(rxLinkChar),
    .rxLinkSpecial(rxLinkSpecial), .rxLinkValid(rxLinkValid),
    .rx_par_bus(rx_par_bus), .rxParBusOeN(rxParBusOeN),
    .rx_special_flag(rx_special_flag), .remote_irq_out(remote_irq_out),
    .remoteIrqOeN(remoteIrqOeN));

  link_partner i_partner (.clk_sys(clk_sys), .tx_par_clk(tx_par_clk),
    .rx_par_clk(rx_par_clk), .rxLinkChar(rxLinkChar),
    .rxLinkSpecial(rxLinkSpecial), .rxLinkValid(rxLinkValid));

  // Record every character handed to the serialiser.
  always @(posedge clk_sys)
    if (txCharValid === 1'b1)
    begin
      lastTx <= txChar;
      txCount <= txCount + 1;
    end

  // --------
  // Bus and compare tasks
  // --------
  task automatic final_report();
    $display("checks %0d errors %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      numErrors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait for hready; running out ends the run as a failure.
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge clk_sys);
    end
    if (n >= 50)
    begin
      numErrors++;
      final_report();
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
    input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  task automatic rx(input logic [11:0] c, input logic s,
    input logic [7:0] eb, input logic ep);
    i_partner.rx_char(c, s);
    chk({24'h0, rx_par_bus}, {24'h0, eb});
    chk({31'h0, remote_irq_out}, {31'h0, ep});
  endtask

  // --------
  // Main sequence
  // --------
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    rchk(link_port_pkg::ADDR_CTRL, link_port_pkg::CTRL_RESET);
    rchk(link_port_pkg::ADDR_MASK, 32'h0);
    rchk(8'h18, 32'h0);
    // Overflow event: sticky, masked, then cleared by a written one.
    for (i = 0; i < 5; i++)
      wr(link_port_pkg::ADDR_TXDATA, 32'h100 + i);
    chk({29'h0, hresp, irq, tx_fifo_empty_flag}, 32'h0);
    wr(link_port_pkg::ADDR_MASK, 32'h10);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    rchk(link_port_pkg::ADDR_STATUS, 32'h10);
    wr(link_port_pkg::ADDR_STATUS, 32'h10);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    rchk(link_port_pkg::ADDR_FIFOSTAT, 32'h14);
    // Clear held low under self-test, which also freezes the FIFO.
    tx_selftest_en_n <= 1'b0;
    tx_fifo_clear_n <= 1'b0;
    repeat (7) i_partner.tx_slot();
    rchk(link_port_pkg::ADDR_FIFOSTAT, 32'h14);
    i_partner.tx_slot();
    rchk(link_port_pkg::ADDR_FIFOSTAT, 32'h08);
    rchk(link_port_pkg::ADDR_STATUS, 32'h08);
    // Clear ignored with the FIFO bypassed.
    tx_fifo_clear_n <= 1'b1;
    tx_selftest_en_n <= 1'b1;
    wr(link_port_pkg::ADDR_CTRL, 32'h2);
    wr(link_port_pkg::ADDR_TXDATA, 32'h2a1);
    wr(link_port_pkg::ADDR_TXDATA, 32'h155);
    tx_selftest_en_n <= 1'b0;
    tx_fifo_clear_n <= 1'b0;
    repeat (8) i_partner.tx_slot();
    rchk(link_port_pkg::ADDR_FIFOSTAT, 32'h02);
    // Leaving self-test sends queued host data again.
    tx_fifo_clear_n <= 1'b1;
    tx_selftest_en_n <= 1'b1;
    wr(link_port_pkg::ADDR_CTRL, 32'h3);
    i_partner.tx_slot();
    chk({22'h0, lastTx}, 32'h2a1);
    // One full pass of the test sequence, and its end marker.
    wr(link_port_pkg::ADDR_STATUS, 32'h1f);
    tx_selftest_en_n <= 1'b0;
    base = txCount;
    repeat (510) i_partner.tx_slot();
    rchk(link_port_pkg::ADDR_STATUS, 32'h0);
    i_partner.tx_slot();
    chk({31'h0, tx_fifo_empty_flag}, 32'h1);
    chk(txCount - base, 32'd511);
    chk({22'h0, lastTx}, 32'h0ff);
    rchk(link_port_pkg::ADDR_STATUS, 32'h04);
    i_partner.tx_slot();
    chk({31'h0, tx_fifo_empty_flag}, 32'h0);
    tx_selftest_en_n <= 1'b1;
    // Receive port: interrupt codes, discard policy, selection, modes.
    addr_match_n <= 1'b0;
    rx_select_n <= 1'b0;
    wr(link_port_pkg::ADDR_STATUS, 32'h1f);
    wr(link_port_pkg::ADDR_CTRL, 32'h13);
    rx(12'h055, 1'b0, 8'h55, 1'b0);
    rx(12'h01c, 1'b1, 8'h55, 1'b1);
    rx(12'h07c, 1'b1, 8'h55, 1'b0);
    rchk(link_port_pkg::ADDR_STATUS, 32'h03);
    wr(link_port_pkg::ADDR_CTRL, 32'h03);
    rx(12'h01c, 1'b1, 8'h1c, 1'b1);
    rx_select_n <= 1'b1;
    i_partner.rx_char(12'h0a5, 1'b0);
    chk({24'h0, rx_par_bus}, 32'h1c);
    chk({30'h0, rxParBusOeN, remoteIrqOeN}, 32'h3);
    rx_select_n <= 1'b0;
    wr(link_port_pkg::ADDR_CTRL, 32'h01);
    rx(12'h1a5, 1'b0, 8'ha5, 1'b1);
    rx(12'h05a, 1'b1, 8'h5a, 1'b0);
    chk({31'h0, rx_special_flag}, 32'h0);
    wr(link_port_pkg::ADDR_CTRL, 32'h02);
    rx(12'h0a6, 1'b0, 8'ha6, 1'b1);
    rx(12'h0c3, 1'b1, 8'hc3, 1'b0);
    chk({31'h0, rx_special_flag}, 32'h1);
    final_report();
  end
endmodule // serial_link_port_test
